// ===== verilog/vbc_pkg.sv
// constants, types and helpers of the video buffer configuration slave
//
// Overview of operation
// - start is data falling while clock high
// - data changes only while clock is low
// - acknowledge own address through ninth clock
// - each byte is eight bits plus acknowledge
// - stop is data rising while clock high
// - transmitter releases data during acknowledge clock
// - one subaddress and one data byte per write
// - read returns exactly one byte
// - channel registers have no defined power-up value
// - stray acknowledge clears after one clock cycle
// - address is 01011 plus two select pins
// - address select pins sampled continuously, never latched
// - first byte after start is the address
// - write stores byte into selected channel register
// - read returns most recently selected channel register
// - subaddresses one to three select channels
// - direction bit zero writes, one reads
// - four configuration fields in each channel register

package vbc_pkg;

	// ****************************************************************
	// bus constants
	// ****************************************************************
	localparam logic [4:0] VBC_ADDR_PREFIX   = 5'h0b;
	localparam logic       VBC_RW_WRITE      = 1'h0;
	localparam logic       VBC_RW_READ       = 1'h1;
	localparam logic [3:0] VBC_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] VBC_LAST_BIT      = 4'h7;
	localparam logic       VBC_LINE_IDLE     = 1'h1;
	localparam int         VBC_LINE_SCL      = 0;
	localparam int         VBC_LINE_SDA      = 1;
	localparam int         VBC_GLITCH_CYCLES = 3;
	localparam int         VBC_GLITCH_MAX    = 8;

	// ****************************************************************
	// channel registers and fields
	// ****************************************************************
	localparam int         VBC_NUM_CHAN       = 3;
	localparam logic [7:0] VBC_SUB_CHAN_ONE   = 8'h01;
	localparam logic [7:0] VBC_SUB_CHAN_TWO   = 8'h02;
	localparam logic [7:0] VBC_SUB_CHAN_THREE = 8'h03;
	localparam logic [7:0] VBC_UNMAPPED_READ  = 8'h00;
	localparam logic [7:0] VBC_SUB_RESET      = 8'h00;
	localparam int         VBC_CLAMP_MSB      = 7;
	localparam int         VBC_CLAMP_LSB      = 6;
	localparam int         VBC_MUX_BIT        = 5;
	localparam int         VBC_LPF_MSB        = 4;
	localparam int         VBC_LPF_LSB        = 3;
	localparam int         VBC_BIAS_MSB       = 2;
	localparam int         VBC_BIAS_LSB       = 0;

	typedef enum logic [9:0]
	{
		VBC_ST_IDLE     = 10'h001,
		VBC_ST_ADDR     = 10'h002,
		VBC_ST_ADDR_ACK = 10'h004,
		VBC_ST_SUB      = 10'h008,
		VBC_ST_SUB_ACK  = 10'h010,
		VBC_ST_DATA     = 10'h020,
		VBC_ST_DATA_ACK = 10'h040,
		VBC_ST_READ     = 10'h080,
		VBC_ST_READ_ACK = 10'h100,
		VBC_ST_IGNORE   = 10'h200
	} vbc_state_e;

	// subaddress to channel number, zero when unmapped
	function automatic logic [1:0] vbc_sub_index(input logic [7:0] sub);
		unique case (sub)
			VBC_SUB_CHAN_ONE:   return 2'h1;
			VBC_SUB_CHAN_TWO:   return 2'h2;
			VBC_SUB_CHAN_THREE: return 2'h3;
			default:            return 2'h0;
		endcase
	endfunction

endpackage

// ===== verilog/vbc_line_if.sv
// filtered two-wire line levels and events
`timescale 1ns/1ns
`default_nettype none

interface vbc_line_if;
	logic scl_level;
	logic sda_level;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	modport prod (output scl_level, sda_level, scl_rise, scl_fall, start_det, stop_det);
	modport cons (input  scl_level, sda_level, scl_rise, scl_fall, start_det, stop_det);
endinterface

`default_nettype wire

// ===== verilog/vbc_deglitch.sv
// synchroniser, deglitch filter and bus condition detector
`timescale 1ns/1ns
`default_nettype none

module vbc_deglitch
	import vbc_pkg::*;
#(
	parameter int GLITCH_CYCLES = VBC_GLITCH_CYCLES
)
(
	input  wire logic  ref_clk,
	input  wire logic  rst_b,
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	vbc_line_if.prod   line
);

	if (GLITCH_CYCLES < 1 || GLITCH_CYCLES > VBC_GLITCH_MAX)
	begin : g_bad
		$error("GLITCH_CYCLES out of range");
	end

	localparam logic [3:0] GLITCH_LAST = 4'(GLITCH_CYCLES - 1);

	logic [1:0] pin_raw;
	logic [1:0] meta_reg;
	logic [1:0] sync_reg;
	logic [1:0] filt_reg;
	logic [1:0] prev_reg;

	assign pin_raw = {sda_in, scl_in};

	// ****************************************************************
	// two-flop synchroniser
	// ****************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			meta_reg <= {2{VBC_LINE_IDLE}};
			sync_reg <= {2{VBC_LINE_IDLE}};
		end
		else
		begin
			meta_reg <= pin_raw;
			sync_reg <= meta_reg;
		end
	end

	// ****************************************************************
	// level filter per line
	// ****************************************************************
	for (genvar i = 0; i < 2; i++)
	begin : g_filt
		logic [3:0] cnt_reg;
		logic       differ;

		assign differ = sync_reg[i] != filt_reg[i];

		always_ff @(posedge ref_clk)
		begin
			if (!rst_b)
			begin
				cnt_reg     <= 4'h0;
				filt_reg[i] <= VBC_LINE_IDLE;
			end
			else if (differ && cnt_reg == GLITCH_LAST)
			begin
				cnt_reg     <= 4'h0;
				filt_reg[i] <= sync_reg[i];
			end
			else
			begin
				cnt_reg     <= differ ? cnt_reg + 4'h1 : 4'h0;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			prev_reg <= {2{VBC_LINE_IDLE}};
		else
			prev_reg <= filt_reg;
	end

	// ****************************************************************
	// edges and bus conditions
	// ****************************************************************
	assign line.scl_level = filt_reg[VBC_LINE_SCL];
	assign line.sda_level = filt_reg[VBC_LINE_SDA];
	assign line.scl_rise  = filt_reg[VBC_LINE_SCL] & ~prev_reg[VBC_LINE_SCL];
	assign line.scl_fall  = ~filt_reg[VBC_LINE_SCL] & prev_reg[VBC_LINE_SCL];
	assign line.start_det = prev_reg[VBC_LINE_SDA] & ~filt_reg[VBC_LINE_SDA]
		& filt_reg[VBC_LINE_SCL] & prev_reg[VBC_LINE_SCL];
	assign line.stop_det  = ~prev_reg[VBC_LINE_SDA] & filt_reg[VBC_LINE_SDA]
		& filt_reg[VBC_LINE_SCL] & prev_reg[VBC_LINE_SCL];

endmodule // vbc_deglitch

`default_nettype wire

// ===== verilog/vbc_chan_regs.sv
// the three channel configuration registers
`timescale 1ns/1ns
`default_nettype none

module vbc_chan_regs
	import vbc_pkg::*;
(
	input  wire logic                          ref_clk,
	input  wire logic                          wr_en,
	input  wire logic [7:0]                    wr_sub,
	input  wire logic [7:0]                    wr_data,
	input  wire logic [7:0]                    rd_sub,
	output logic      [7:0]                    rd_data,
	output logic      [VBC_NUM_CHAN-1:0][7:0]  cfg
);

	logic [7:0] cfg_reg [VBC_NUM_CHAN];
	logic [1:0] wr_idx;
	logic [1:0] rd_idx;
	logic [1:0] wr_slot;
	logic [1:0] rd_slot;

	assign wr_idx  = vbc_sub_index(wr_sub);
	assign rd_idx  = vbc_sub_index(rd_sub);
	assign wr_slot = wr_idx - 2'h1;
	assign rd_slot = rd_idx - 2'h1;

	// ****************************************************************
	// storage, deliberately without reset
	// ****************************************************************
	// random power-up contents
	always_ff @(posedge ref_clk)
	begin
		if (wr_en && wr_idx != 2'h0)
			cfg_reg[wr_slot] <= wr_data;
	end

	always_ff @(posedge ref_clk)
	begin
		rd_data <= (rd_idx == 2'h0) ? VBC_UNMAPPED_READ : cfg_reg[rd_slot];
	end

	for (genvar i = 0; i < VBC_NUM_CHAN; i++)
	begin : g_out
		assign cfg[i] = cfg_reg[i];
	end

endmodule // vbc_chan_regs

`default_nettype wire

// ===== verilog/vbc_i2c_slave.sv
// two-wire configuration slave of the three-channel video buffer
`timescale 1ns/1ns
`default_nettype none

module vbc_i2c_slave
	import vbc_pkg::*;
#(
	parameter int GLITCH_CYCLES = VBC_GLITCH_CYCLES
)
(
	input  wire logic                          ref_clk,
	input  wire logic                          rst_b,
	input  wire logic                          scl_in,
	input  wire logic                          sda_in,
	output logic                               sda_out,
	output logic                               sda_oe,
	input  wire logic                          addr_select_high_pin,
	input  wire logic                          addr_select_low_pin,
	output logic                               link_active,
	output logic      [VBC_NUM_CHAN-1:0][1:0]  clamp_filter_sel,
	output logic      [VBC_NUM_CHAN-1:0]       input_mux_sel,
	output logic      [VBC_NUM_CHAN-1:0][1:0]  video_filter_sel,
	output logic      [VBC_NUM_CHAN-1:0][2:0]  bias_mode_sel
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	vbc_line_if line ();

	vbc_state_e                  state_reg;
	vbc_state_e                  state_next;
	logic       [3:0]            bit_cnt_reg;
	logic       [3:0]            bit_cnt_next;
	logic       [7:0]            shift_reg;
	logic       [7:0]            shift_next;
	logic       [7:0]            tx_reg;
	logic       [7:0]            tx_next;
	logic       [7:0]            sub_reg;
	logic       [7:0]            sub_next;
	logic                        oe_reg;
	logic                        oe_next;
	logic       [1:0]            asel_meta_reg;
	logic       [1:0]            asel_reg;
	logic       [6:0]            own_addr;
	logic                        addr_match;
	logic                        rw_bit;
	logic                        byte_full;
	logic                        byte_state;
	logic                        take_bit;
	logic                        ack_fall;
	logic                        wr_en;
	logic       [7:0]            rd_data;
	logic       [VBC_NUM_CHAN-1:0][7:0] cfg;

	// ****************************************************************
	// line conditioning
	// ****************************************************************
	vbc_deglitch #(
		.GLITCH_CYCLES (GLITCH_CYCLES)
	) u_deglitch (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.line    (line.prod)
	);

	// ****************************************************************
	// address select pins
	// ****************************************************************
	// synchronised, never latched
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			asel_meta_reg <= 2'h0;
			asel_reg      <= 2'h0;
		end
		else
		begin
			asel_meta_reg <= {addr_select_high_pin, addr_select_low_pin};
			asel_reg      <= asel_meta_reg;
		end
	end

	assign own_addr   = {VBC_ADDR_PREFIX, asel_reg};
	assign addr_match = shift_reg[7:1] == own_addr;
	assign rw_bit     = shift_reg[0];

	// ****************************************************************
	// byte framing
	// ****************************************************************
	assign byte_state = state_reg == VBC_ST_ADDR
		|| state_reg == VBC_ST_SUB
		|| state_reg == VBC_ST_DATA;
	assign take_bit   = byte_state && line.scl_rise && bit_cnt_reg != VBC_BITS_PER_BYTE;
	assign byte_full  = line.scl_fall && bit_cnt_reg == VBC_BITS_PER_BYTE;
	assign ack_fall   = line.scl_fall;
	assign wr_en      = state_reg == VBC_ST_DATA && byte_full
		&& !line.start_det && !line.stop_det;

	// ****************************************************************
	// transaction sequencer
	// ****************************************************************
	always_comb
	begin
		state_next   = state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next   = shift_reg;
		tx_next      = tx_reg;
		sub_next     = sub_reg;
		oe_next      = oe_reg;

		if (take_bit)
		begin
			shift_next   = {shift_reg[6:0], line.sda_level};
			bit_cnt_next = bit_cnt_reg + 4'h1;
		end

		if (line.start_det)
		begin
			state_next   = VBC_ST_ADDR;
			bit_cnt_next = 4'h0;
			oe_next      = 1'h0;
		end
		else if (line.stop_det)
		begin
			state_next   = VBC_ST_IDLE;
			bit_cnt_next = 4'h0;
			oe_next      = 1'h0;
		end
		else
		begin
			unique case (state_reg)
				VBC_ST_IDLE,
				VBC_ST_IGNORE:
				begin
					oe_next = 1'h0;
				end
				VBC_ST_ADDR:
				begin
					if (byte_full)
					begin
						state_next = addr_match ? VBC_ST_ADDR_ACK : VBC_ST_IGNORE;
						oe_next    = addr_match;
					end
				end
				VBC_ST_ADDR_ACK:
				begin
					if (ack_fall)
					begin
						bit_cnt_next = 4'h0;
						if (rw_bit == VBC_RW_READ)
						begin
							state_next = VBC_ST_READ;
							tx_next    = rd_data;
							oe_next    = ~rd_data[7];
						end
						else
						begin
							state_next = VBC_ST_SUB;
							oe_next    = 1'h0;
						end
					end
				end
				VBC_ST_SUB:
				begin
					if (byte_full)
					begin
						state_next = VBC_ST_SUB_ACK;
						sub_next   = shift_reg;
						oe_next    = 1'h1;
					end
				end
				VBC_ST_SUB_ACK:
				begin
					if (ack_fall)
					begin
						state_next   = VBC_ST_DATA;
						bit_cnt_next = 4'h0;
						oe_next      = 1'h0;
					end
				end
				VBC_ST_DATA:
				begin
					if (byte_full)
					begin
						state_next = VBC_ST_DATA_ACK;
						oe_next    = 1'h1;
					end
				end
				VBC_ST_DATA_ACK:
				begin
					if (ack_fall)
					begin
						state_next   = VBC_ST_IGNORE;
						bit_cnt_next = 4'h0;
						oe_next      = 1'h0;
					end
				end
				VBC_ST_READ:
				begin
					if (line.scl_fall)
					begin
						if (bit_cnt_reg == VBC_LAST_BIT)
						begin
							state_next = VBC_ST_READ_ACK;
							oe_next    = 1'h0;
						end
						else
						begin
							tx_next      = {tx_reg[6:0], 1'h0};
							oe_next      = ~tx_reg[6];
							bit_cnt_next = bit_cnt_reg + 4'h1;
						end
					end
				end
				VBC_ST_READ_ACK:
				begin
					if (ack_fall)
					begin
						state_next   = VBC_ST_IGNORE;
						bit_cnt_next = 4'h0;
						oe_next      = 1'h0;
					end
				end
				default:
				begin
					state_next   = VBC_ST_IDLE;
					bit_cnt_next = 4'h0;
					oe_next      = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			state_reg   <= VBC_ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			tx_reg      <= 8'h00;
			sub_reg     <= VBC_SUB_RESET;
			oe_reg      <= 1'h0;
		end
		else
		begin
			state_reg   <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= shift_next;
			tx_reg      <= tx_next;
			sub_reg     <= sub_next;
			oe_reg      <= oe_next;
		end
	end

	// ****************************************************************
	// channel register file
	// ****************************************************************
	vbc_chan_regs u_regs (
		.ref_clk (ref_clk),
		.wr_en   (wr_en),
		.wr_sub  (sub_reg),
		.wr_data (shift_reg),
		.rd_sub  (sub_reg),
		.rd_data (rd_data),
		.cfg     (cfg)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign sda_out     = 1'h0;
	assign sda_oe      = oe_reg;
	assign link_active = state_reg != VBC_ST_IDLE && state_reg != VBC_ST_IGNORE;

	for (genvar c = 0; c < VBC_NUM_CHAN; c++)
	begin : g_fields
		assign clamp_filter_sel[c] = cfg[c][VBC_CLAMP_MSB:VBC_CLAMP_LSB];
		assign input_mux_sel[c]    = cfg[c][VBC_MUX_BIT];
		assign video_filter_sel[c] = cfg[c][VBC_LPF_MSB:VBC_LPF_LSB];
		assign bias_mode_sel[c]    = cfg[c][VBC_BIAS_MSB:VBC_BIAS_LSB];
	end

endmodule // vbc_i2c_slave

`default_nettype wire

// ===== sim/vbc_master_model.sv
// two-wire bus master model that drives the slave's clock and data lines
`timescale 1ns/1ns
`default_nettype none

module vbc_master_model
(
	input  wire logic  ref_clk,
	input  wire logic  sda_oe,
	output logic       scl,
	output logic       sda
);
	localparam int QUARTER = 10;
	logic  pull_low;

	assign sda = !(pull_low || sda_oe);

	initial
	begin
		scl = 1'b1;
		pull_low = 1'b0;
	end

	task automatic quarter();
		repeat (QUARTER) @(posedge ref_clk);
	endtask

	task automatic start();
		quarter();
		pull_low <= 1'b1;
		quarter();
		scl <= 1'b0;
	endtask

	task automatic stop();
		quarter();
		pull_low <= 1'b1;
		quarter();
		scl <= 1'b1;
		quarter();
		pull_low <= 1'b0;
		quarter();
	endtask

	task automatic clock_bit(input logic b, output logic r);
		quarter();
		pull_low <= !b;
		quarter();
		scl <= 1'b1;
		quarter();
		r = sda;
		quarter();
		scl <= 1'b0;
	endtask

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clock_bit(d[i], r);
		clock_bit(1'b1, r);
		ack = !r;
	endtask

	// master answers the byte, mack high means ack
	task automatic get_byte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			clock_bit(1'b1, d[i]);
		clock_bit(!mack, r);
	endtask
endmodule // vbc_master_model

`default_nettype wire

// ===== sim/vbc_i2c_slave_props.sv
// concurrent checks of the configuration slave's bus behaviour
`timescale 1ns/1ns
`default_nettype none

module vbc_i2c_slave_props
	import vbc_pkg::*;
#(
	parameter int GLITCH_CYCLES = VBC_GLITCH_CYCLES
)
(
	input  wire logic  ref_clk,
	input  wire logic  rst_b,
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	input  wire logic  sda_out,
	input  wire logic  sda_oe,
	input  wire logic  addr_select_high_pin,
	input  wire logic  addr_select_low_pin,
	input  wire logic  link_active
);
	logic [5:0]  rise_cnt;
	logic [7:0]  shift;
	logic        dir_rd;
	logic        addr_ok;
	logic        addr_match;

	// ****************************************************************
	// clock count since the last start
	// ****************************************************************
	assign addr_match = shift[7:1] == {VBC_ADDR_PREFIX, addr_select_high_pin, addr_select_low_pin};

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			rise_cnt <= 6'h3f;
		else if (scl_in && $fell(sda_in))
			rise_cnt <= 6'h00;
		else if ($rose(scl_in) && rise_cnt != 6'h3f)
			rise_cnt <= rise_cnt + 6'h01;
	end

	always_ff @(posedge ref_clk)
	begin
		if ($rose(scl_in))
			shift <= {shift[6:0], sda_in};
		if (rise_cnt == 6'h08)
		begin
			dir_rd <= shift[0];
			addr_ok <= addr_match;
		end
	end

	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	chk_hold_high:
		assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("slave data moved while clock high");
	chk_move_low:
		assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 4))
		else $error("slave data moved outside the low phase");
	chk_drain_low:
		assert property (sda_oe |-> sda_out == 1'b0)
		else $error("slave drives a high level");
	chk_start_seen:
		assert property (scl_in && $fell(sda_in) |-> ##[1:16] link_active)
		else $error("start not taken");
	chk_stop_idle:
		assert property (scl_in && $rose(sda_in) |-> ##[1:16] !link_active)
		else $error("stop did not free the slave");
	chk_addr_ack:
		assert property ($rose(scl_in) && rise_cnt == 6'h08 |-> sda_oe == addr_match)
		else $error("address acknowledge wrong");
	chk_write_ack:
		assert property ($rose(scl_in) && !dir_rd && addr_ok
			&& (rise_cnt == 6'h11 || rise_cnt == 6'h1a) |-> sda_oe)
		else $error("write byte not acknowledged");
	chk_write_end:
		assert property ($rose(scl_in) && !dir_rd && rise_cnt >= 6'h1b
			&& rise_cnt != 6'h3f |-> !sda_oe)
		else $error("slave drove after the data byte");
	chk_read_end:
		assert property ($rose(scl_in) && dir_rd && addr_ok && rise_cnt >= 6'h11
			&& rise_cnt != 6'h3f |-> !sda_oe)
		else $error("slave drove after the read byte");
endmodule // vbc_i2c_slave_props

bind vbc_i2c_slave vbc_i2c_slave_props #(.GLITCH_CYCLES(GLITCH_CYCLES)) vbc_i2c_slave_props_i
(
	.ref_clk(ref_clk),
	.rst_b(rst_b),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.addr_select_high_pin(addr_select_high_pin),
	.addr_select_low_pin(addr_select_low_pin),
	.link_active(link_active)
);

`default_nettype wire

// ===== sim/vbc_i2c_slave_test.sv
// self-checking bench of the two-wire configuration slave
`timescale 1ns/1ns
`default_nettype none

module vbc_i2c_slave_test
	import vbc_pkg::*;
;
	logic                          ref_clk;
	logic                          rst_b;
	logic                          scl;
	logic                          sda;
	logic                          sda_oe;
	logic                          pin_hi;
	logic                          pin_lo;
	logic [VBC_NUM_CHAN-1:0][1:0]  clamp_sel;
	logic [VBC_NUM_CHAN-1:0]       mux_sel;
	logic [VBC_NUM_CHAN-1:0][1:0]  lpf_sel;
	logic [VBC_NUM_CHAN-1:0][2:0]  bias_sel;
	logic [7:0]                    shadow [1:3] = '{8'hf5, 8'h2a, 8'h93};
	logic [3:0]                    acks;
	logic [7:0]                    rd0;
	logic [7:0]                    rd1;
	int                            error_cnt = 0;
	int                            cmp_count = 0;

	vbc_i2c_slave vbc_i2c_slave_i
	(
		.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe(sda_oe), .addr_select_high_pin(pin_hi), .addr_select_low_pin(pin_lo),
		.link_active(), .clamp_filter_sel(clamp_sel), .input_mux_sel(mux_sel),
		.video_filter_sel(lpf_sel), .bias_mode_sel(bias_sel)
	);

	vbc_master_model vbc_master_model_i
	(
		.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ****************************************************************
	// access tasks
	// ****************************************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [6:0] dev();
		return {VBC_ADDR_PREFIX, pin_hi, pin_lo};
	endfunction

	// nb bytes after the address: subaddress, data, inverted data
	task automatic reg_write(input logic [6:0] d, input logic [7:0] sub, input logic [7:0] data,
		input int nb);
		acks = 4'h0;
		vbc_master_model_i.start();
		vbc_master_model_i.put_byte({d, VBC_RW_WRITE}, acks[3]);
		vbc_master_model_i.put_byte(sub, acks[2]);
		if (nb > 1)
			vbc_master_model_i.put_byte(data, acks[1]);
		if (nb > 2)
			vbc_master_model_i.put_byte(~data, acks[0]);
		vbc_master_model_i.stop();
	endtask

	task automatic reg_read(input logic [7:0] sub, input logic more);
		reg_write(dev(), sub, 8'h00, 1);
		vbc_master_model_i.start();
		vbc_master_model_i.put_byte({dev(), VBC_RW_READ}, acks[3]);
		vbc_master_model_i.get_byte(more, rd0);
		if (more)
			vbc_master_model_i.get_byte(1'b0, rd1);
		vbc_master_model_i.stop();
	endtask

	task automatic check_all();
		for (int i = 1; i <= 3; i++)
			check({clamp_sel[i-1], mux_sel[i-1], lpf_sel[i-1], bias_sel[i-1]}, shadow[i]);
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial
	begin
		#200000;
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		results();
	end

	initial
	begin
		rst_b = 1'b0;
		pin_hi = 1'b0;
		pin_lo = 1'b1;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (10) @(posedge ref_clk);
		reg_write(7'h00, 8'h00, 8'h00, 1);
		check({4'h0, acks}, 8'h00);
		for (int i = 1; i <= 3; i++)
		begin
			reg_write(dev(), i[7:0], shadow[i], 2);
			check({4'h0, acks}, 8'h0e);
		end
		check_all();
		for (int i = 1; i <= 3; i++)
		begin
			reg_read(i[7:0], 1'b0);
			check(rd0, shadow[i]);
			check({4'h0, acks}, 8'h0c);
		end
		for (int k = 0; k < 3; k++)
		begin
			reg_write(dev(), (k == 0) ? 8'h00 : (k == 1) ? 8'h04 : 8'hff, 8'h5a, 2);
			check({4'h0, acks}, 8'h0e);
		end
		check_all();
		reg_read(8'h04, 1'b0);
		check(rd0, VBC_UNMAPPED_READ);
		reg_write(dev(), 8'h02, 8'h6c, 3);
		shadow[2] = 8'h6c;
		check({4'h0, acks}, 8'h0e);
		check_all();
		reg_read(8'h03, 1'b1);
		check(rd0, shadow[3]);
		check(rd1, 8'hff);
		for (int p = 0; p < 4; p++)
		begin
			pin_hi <= p[1];
			pin_lo <= p[0];
			repeat (10) @(posedge ref_clk);
			reg_write(dev() ^ (p[0] ? 7'h08 : 7'h02), 8'h01, 8'h00, 2);
			check({4'h0, acks}, 8'h00);
			reg_write(dev(), 8'h01, 8'h10 + p[7:0], 2);
			shadow[1] = 8'h10 + p[7:0];
			check({4'h0, acks}, 8'h0e);
			check_all();
		end
		results();
	end
endmodule // vbc_i2c_slave_test

`default_nettype wire
